//--- usb_ep_status_regs.vh
// Constants of the per-endpoint transaction status block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef USB_EP_STATUS_REGS_VH
`define USB_EP_STATUS_REGS_VH
// Register addresses on the plain register port.
`define ADDR_RX_STATUS 8'he2
`define ADDR_TX_STATUS 8'hf2
`define ADDR_EP_SELECT 8'hf1
`define ADDR_EP_CONTROL 8'he1
`define ADDR_FIFO_FLAGS 8'hf0
// Reset values.
`define STATUS_RESET 8'h00
`define EP_CONTROL_RESET 8'h00
`define EP_CONTROL_EP0_RESET 8'h20
// Transmit status field positions.
`define TX_TOGGLE_BIT 7
`define TX_FLUSHED_BIT 4
`define TX_OVERWRITE_BIT 3
`define TX_VOID_BIT 2
`define TX_ERROR_BIT 1
`define TX_ACKED_BIT 0
// Receive status field positions.
`define RX_TOGGLE_BIT 7
`define RX_SETUP_BIT 6
`define RX_START_OVW_BIT 5
`define RX_END_OVW_BIT 4
`define RX_OVERWRITE_BIT 3
`define RX_VOID_BIT 2
`define RX_ERROR_BIT 1
`define RX_ACKED_BIT 0
// Endpoint control field positions.
`define CTL_RX_STALL_BIT 7
`define CTL_TX_STALL_BIT 6
`define CTL_CONTROL_EP_BIT 5
`define CTL_ISO_BIT 4
// Transmit FIFO flag value that marks a stale packet at SOF.
`define TX_FIFO_STALE 2'h3
// Handshake answer codes.
`define HS_NONE 2'h0
`define HS_ACK 2'h1
`define HS_NAK 2'h2
`define HS_STALL 2'h3
`endif

//--- ep_outcome_slot.v
// One deferred outcome slot: holds a three-bit outcome until SOF.
// Assumes the caller presents capture and release as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module ep_outcome_slot #(
    parameter WIDTH = 3
) (
    input wire clk,
    input wire sys_rst,
    input wire capture,
    input wire [WIDTH-1:0] capture_value,
    input wire release_now,
    output reg pending,
    output reg [WIDTH-1:0] held_value
);
    // A capture in the SOF cycle wins, so a late outcome is kept for the next frame.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'b0;
            held_value <= {WIDTH{1'b0}};
        end else if (capture) begin
            pending <= 1'b1;
            held_value <= capture_value;
        end else if (release_now) begin
            pending <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- usb_endpoint_transaction_status.v
// Per-endpoint transaction status for a four-endpoint USB function interface.
// Assumes the serial engine gives one-cycle pulses synchronous to clk, tagged with ep.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep_status_regs.vh"
module usb_endpoint_transaction_status #(
    parameter EP_COUNT = 4,
    parameter EP_BITS = 2
) (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire [EP_BITS-1:0] tok_ep,
    input wire tok_setup,
    input wire tok_in,
    input wire tok_out,
    input wire sof,
    input wire tx_fifo_ready,
    input wire rx_fifo_ready,
    input wire [2*EP_COUNT-1:0] tx_fifo_set_flags,
    input wire tx_end,
    input wire tx_ack_seen,
    input wire rx_end,
    input wire rx_bad,
    input wire setup_handshake,
    output reg [1:0] handshake,
    output reg handshake_valid,
    output reg tx_data_toggle,
    output reg [EP_COUNT-1:0] rx_fifo_locked,
    output reg [EP_COUNT-1:0] tx_flush_strobe,
    output reg [EP_COUNT-1:0] rx_fifo_reset
);
    // Per-endpoint status state.
    reg [EP_COUNT-1:0] tx_toggle_bit;
    reg [EP_COUNT-1:0] tx_stale_flushed;
    reg [EP_COUNT-1:0] tx_void_flag;
    reg [EP_COUNT-1:0] tx_error_flag;
    reg [EP_COUNT-1:0] tx_acked_flag;
    reg [EP_COUNT-1:0] rx_toggle_bit;
    reg [EP_COUNT-1:0] setup_received_flag;
    reg [EP_COUNT-1:0] start_overwrite_flag;
    reg [EP_COUNT-1:0] end_overwrite_flag;
    reg [EP_COUNT-1:0] rx_void_flag;
    reg [EP_COUNT-1:0] rx_error_flag;
    reg [EP_COUNT-1:0] rx_acked_flag;
    reg [EP_COUNT-1:0] tx_done_bit;
    reg [EP_COUNT-1:0] rx_done_bit;
    reg [7:0] ep_control [0:EP_COUNT-1];
    reg [EP_BITS-1:0] endpoint_selector;
    reg [EP_BITS-1:0] cur_ep;
    reg in_active;
    reg out_active;
    reg cur_void;
    reg cur_setup;
    wire [7:0] ctl = ep_control[tok_ep];
    wire [7:0] cur_ctl = ep_control[cur_ep];
    wire cur_iso = cur_ctl[`CTL_ISO_BIT];
    wire [EP_COUNT-1:0] tx_slot_pending;
    wire [EP_COUNT-1:0] rx_slot_pending;
    wire [3*EP_COUNT-1:0] tx_slot_value;
    wire [3*EP_COUNT-1:0] rx_slot_value;

    // One-hot decode of an endpoint number, used by several paths.
    function [EP_COUNT-1:0] ep_hot;
        input [EP_BITS-1:0] ep;
        begin
            ep_hot = {{(EP_COUNT-1){1'b0}}, 1'b1} << ep;
        end
    endfunction

    // Outcome triple packing: void, error, ack.
    function [2:0] outcome;
        input v;
        input e;
        input a;
        begin
            outcome = {v, e & ~v, a & ~e & ~v};
        end
    endfunction

    wire rx_locked_now = start_overwrite_flag[tok_ep] | end_overwrite_flag[tok_ep];
    wire wr_tx = reg_write && (reg_addr == `ADDR_TX_STATUS);
    wire wr_rx = reg_write && (reg_addr == `ADDR_RX_STATUS);
    wire [EP_COUNT-1:0] sel_hot = ep_hot(endpoint_selector);
    wire [EP_COUNT-1:0] cur_hot = ep_hot(cur_ep);
    wire [EP_COUNT-1:0] tok_hot = ep_hot(tok_ep);
    wire tx_end_evt = tx_end && in_active;
    wire rx_end_evt = rx_end && out_active;
    wire [2:0] tx_result = outcome(cur_void, ~tx_ack_seen, tx_ack_seen);
    wire [2:0] rx_result = outcome(cur_void, rx_bad, ~rx_bad);

    // Deferred outcome slots for isochronous endpoints.
    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g = g + 1) begin : slot
            ep_outcome_slot #(.WIDTH(3)) tx_slot (
                .clk(clk),
                .sys_rst(sys_rst),
                .capture(tx_end_evt && cur_iso && cur_hot[g]),
                .capture_value(tx_result),
                .release_now(sof),
                .pending(tx_slot_pending[g]),
                .held_value(tx_slot_value[3*g+2:3*g])
            );
            ep_outcome_slot #(.WIDTH(3)) rx_slot (
                .clk(clk),
                .sys_rst(sys_rst),
                .capture(rx_end_evt && cur_iso && cur_hot[g]),
                .capture_value(rx_result),
                .release_now(sof),
                .pending(rx_slot_pending[g]),
                .held_value(rx_slot_value[3*g+2:3*g])
            );
        end
    endgenerate

    // Token handshake decision; setup-received NAK outranks stall.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            handshake <= `HS_NONE;
            handshake_valid <= 1'b0;
            tx_data_toggle <= 1'b0;
            cur_ep <= {EP_BITS{1'b0}};
            in_active <= 1'b0;
            out_active <= 1'b0;
            cur_void <= 1'b0;
            cur_setup <= 1'b0;
        end else begin
            handshake_valid <= 1'b0;
            handshake <= `HS_NONE;
            if (tok_in) begin
                cur_ep <= tok_ep;
                in_active <= 1'b1;
                cur_setup <= 1'b0;
                tx_data_toggle <= tx_toggle_bit[tok_ep];
                if (setup_received_flag[tok_ep]) begin
                    handshake <= `HS_NAK;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b0;
                end else if (ctl[`CTL_TX_STALL_BIT]) begin
                    handshake <= `HS_STALL;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b1;
                end else if (!tx_fifo_ready) begin
                    handshake <= `HS_NAK;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b1;
                end else begin
                    cur_void <= 1'b0;
                end
            end else if (tok_out || tok_setup) begin
                cur_ep <= tok_ep;
                out_active <= 1'b1;
                cur_setup <= tok_setup;
                if (tok_out && setup_received_flag[tok_ep]) begin
                    handshake <= `HS_NAK;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b0;
                end else if (tok_out && ctl[`CTL_RX_STALL_BIT] && !ctl[`CTL_CONTROL_EP_BIT]) begin
                    handshake <= `HS_STALL;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b1;
                end else if (tok_out && (rx_locked_now || !rx_fifo_ready)) begin
                    handshake <= `HS_NAK;
                    handshake_valid <= 1'b1;
                    cur_void <= 1'b1;
                end else begin
                    cur_void <= 1'b0;
                end
            end else begin
                if (tx_end) begin
                    in_active <= 1'b0;
                end
                if (rx_end) begin
                    out_active <= 1'b0;
                    if (!cur_void && !rx_bad) begin
                        handshake <= `HS_ACK;
                        handshake_valid <= 1'b1;
                    end
                end
            end
        end
    end

    // Transmit status flags per endpoint; each process keeps its own loop index.
    always @(posedge clk or posedge sys_rst) begin : tx_flags
        integer i;
        if (sys_rst) begin
            tx_toggle_bit <= {EP_COUNT{1'b0}};
            tx_stale_flushed <= {EP_COUNT{1'b0}};
            tx_void_flag <= {EP_COUNT{1'b0}};
            tx_error_flag <= {EP_COUNT{1'b0}};
            tx_acked_flag <= {EP_COUNT{1'b0}};
            tx_done_bit <= {EP_COUNT{1'b0}};
            tx_flush_strobe <= {EP_COUNT{1'b0}};
        end else begin
            for (i = 0; i < EP_COUNT; i = i + 1) begin
                tx_flush_strobe[i] <= 1'b0;
                if (wr_tx && sel_hot[i] && reg_wdata[`TX_OVERWRITE_BIT]) begin
                    tx_toggle_bit[i] <= reg_wdata[`TX_TOGGLE_BIT];
                end
                // flip on ACK; flip on SETUP
                if ((tx_end_evt && cur_hot[i] && tx_ack_seen && !cur_void)
                        || (tok_setup && tok_hot[i])) begin
                    tx_toggle_bit[i] <= ~tx_toggle_bit[i];
                end
                if ((sof && tx_fifo_set_flags[2*i+1 -: 2] == `TX_FIFO_STALE
                        && ep_control[i][`CTL_ISO_BIT])
                        || (wr_tx && sel_hot[i] && reg_wdata[`TX_FLUSHED_BIT])) begin
                    tx_stale_flushed[i] <= 1'b1;
                    tx_flush_strobe[i] <= 1'b1;
                end
                if (tx_end_evt && cur_hot[i] && !cur_iso) begin
                    {tx_void_flag[i], tx_error_flag[i], tx_acked_flag[i]} <= tx_result;
                    if (!cur_void) begin
                        tx_done_bit[i] <= 1'b1;
                    end
                end else if (sof && tx_slot_pending[i]) begin
                    {tx_void_flag[i], tx_error_flag[i], tx_acked_flag[i]}
                        <= tx_slot_value[3*i+2 -: 3];
                    if (!tx_slot_value[3*i+2]) begin
                        tx_done_bit[i] <= 1'b1;
                    end
                end else if (reg_write && reg_addr == `ADDR_FIFO_FLAGS && reg_wdata[i]) begin
                    tx_done_bit[i] <= 1'b0;
                end
            end
        end
    end

    // Receive status flags and FIFO lock per endpoint.
    always @(posedge clk or posedge sys_rst) begin : rx_flags
        integer i;
        if (sys_rst) begin
            rx_toggle_bit <= {EP_COUNT{1'b0}};
            setup_received_flag <= {EP_COUNT{1'b0}};
            start_overwrite_flag <= {EP_COUNT{1'b0}};
            end_overwrite_flag <= {EP_COUNT{1'b0}};
            rx_void_flag <= {EP_COUNT{1'b0}};
            rx_error_flag <= {EP_COUNT{1'b0}};
            rx_acked_flag <= {EP_COUNT{1'b0}};
            rx_done_bit <= {EP_COUNT{1'b0}};
            rx_fifo_locked <= {EP_COUNT{1'b0}};
            rx_fifo_reset <= {EP_COUNT{1'b0}};
        end else begin
            for (i = 0; i < EP_COUNT; i = i + 1) begin
                rx_fifo_reset[i] <= 1'b0;
                if (wr_rx && sel_hot[i] && reg_wdata[`RX_OVERWRITE_BIT]) begin
                    rx_toggle_bit[i] <= reg_wdata[`RX_TOGGLE_BIT];
                end
                // Software clears setup-received and end-overwrite by writing zero.
                if (wr_rx && sel_hot[i] && !reg_wdata[`RX_SETUP_BIT]) begin
                    setup_received_flag[i] <= 1'b0;
                end
                if (wr_rx && sel_hot[i] && !reg_wdata[`RX_END_OVW_BIT]) begin
                    end_overwrite_flag[i] <= 1'b0;
                end
                if (rx_end_evt && cur_hot[i] && !cur_setup && !cur_void && !rx_bad) begin
                    rx_toggle_bit[i] <= ~rx_toggle_bit[i];
                end
                if (tok_setup && tok_hot[i]) begin
                    setup_received_flag[i] <= 1'b1;
                    rx_toggle_bit[i] <= 1'b1;
                    if (ep_control[i][`CTL_CONTROL_EP_BIT]) begin
                        start_overwrite_flag[i] <= 1'b1;
                        rx_fifo_reset[i] <= 1'b1;
                    end
                end
                if (setup_handshake && cur_hot[i] && start_overwrite_flag[i]) begin
                    start_overwrite_flag[i] <= 1'b0;
                    end_overwrite_flag[i] <= 1'b1;
                end
                rx_fifo_locked[i] <= start_overwrite_flag[i] | end_overwrite_flag[i]
                    | (tok_setup && tok_hot[i] && ep_control[i][`CTL_CONTROL_EP_BIT]);
                if (rx_end_evt && cur_hot[i] && !cur_iso) begin
                    {rx_void_flag[i], rx_error_flag[i], rx_acked_flag[i]} <= rx_result;
                    if (!cur_void) begin
                        rx_done_bit[i] <= 1'b1;
                    end
                end else if (sof && rx_slot_pending[i]) begin
                    {rx_void_flag[i], rx_error_flag[i], rx_acked_flag[i]}
                        <= rx_slot_value[3*i+2 -: 3];
                    if (!rx_slot_value[3*i+2]) begin
                        rx_done_bit[i] <= 1'b1;
                    end
                end else if (reg_write && reg_addr == `ADDR_FIFO_FLAGS
                        && reg_wdata[EP_COUNT+i]) begin
                    rx_done_bit[i] <= 1'b0;
                end
            end
        end
    end

    // Endpoint selector and control registers; endpoint 0 starts as control.
    always @(posedge clk or posedge sys_rst) begin : ep_regs
        integer i;
        if (sys_rst) begin
            endpoint_selector <= {EP_BITS{1'b0}};
            for (i = 0; i < EP_COUNT; i = i + 1) begin
                ep_control[i] <= (i == 0) ? `EP_CONTROL_EP0_RESET : `EP_CONTROL_RESET;
            end
        end else if (reg_write && reg_addr == `ADDR_EP_SELECT) begin
            endpoint_selector <= reg_wdata[EP_BITS-1:0];
        end else if (reg_write && reg_addr == `ADDR_EP_CONTROL) begin
            ep_control[endpoint_selector] <= reg_wdata;
        end
    end

    // Read data stand for one cycle after the strobe; overwrite bits read zero.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= `STATUS_RESET;
        end else if (reg_read) begin
            case (reg_addr)
                `ADDR_TX_STATUS: reg_rdata <= {tx_toggle_bit[endpoint_selector], 2'h0,
                    tx_stale_flushed[endpoint_selector], 1'b0,
                    tx_void_flag[endpoint_selector], tx_error_flag[endpoint_selector],
                    tx_acked_flag[endpoint_selector]};
                `ADDR_RX_STATUS: reg_rdata <= {rx_toggle_bit[endpoint_selector],
                    setup_received_flag[endpoint_selector],
                    start_overwrite_flag[endpoint_selector],
                    end_overwrite_flag[endpoint_selector], 1'b0,
                    rx_void_flag[endpoint_selector], rx_error_flag[endpoint_selector],
                    rx_acked_flag[endpoint_selector]};
                `ADDR_EP_SELECT: reg_rdata <= {{(8-EP_BITS){1'b0}}, endpoint_selector};
                `ADDR_EP_CONTROL: reg_rdata <= ep_control[endpoint_selector];
                `ADDR_FIFO_FLAGS: reg_rdata <= {rx_done_bit, tx_done_bit};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- usb_host_model.sv
// Host model: sends tokens, end-of-packet strobes, SOF and setup handshakes.
// Assumes send is called just after a rising clk edge; it keeps the last handshake seen.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep_status_regs.vh"
module usb_host_model (
    input wire logic clk,
    input wire logic [1:0] handshake,
    input wire logic handshake_valid,
    output logic [1:0] tok_ep,
    output wire logic tok_setup,
    output wire logic tok_in,
    output wire logic tok_out,
    output wire logic sof,
    output wire logic tx_end,
    output logic tx_ack_seen,
    output wire logic rx_end,
    output logic rx_bad,
    output wire logic setup_handshake,
    output logic [1:0] last_hs
);
    logic [6:0] pulses = 7'h00;
    // One strobe at a time, each one cycle long.
    assign {setup_handshake, rx_end, tx_end, sof, tok_out, tok_in, tok_setup} = pulses;
    initial begin
        tok_ep = 2'h0;
        tx_ack_seen = 1'b0;
        rx_bad = 1'b1;
    end
    // A new transfer forgets the old answer, so a missing handshake reads as none.
    always @(posedge clk) begin
        if (pulses[5:4] != 2'h0 || pulses[2:0] != 3'h0) begin
            last_hs <= `HS_NONE;
        end else if (handshake_valid) begin
            last_hs <= handshake;
        end
    end
    // Qualifying levels flip once the strobe ends, so nothing stale is left on them.
    task send(input logic [6:0] which, input logic [1:0] ep, input logic good);
        @(posedge clk);
        tok_ep <= ep;
        tx_ack_seen <= good;
        rx_bad <= !good;
        pulses <= which;
        @(posedge clk);
        pulses <= 7'h00;
        tok_ep <= ~ep;
        tx_ack_seen <= !good;
        rx_bad <= good;
    endtask
endmodule
`default_nettype wire

//--- usb_endpoint_transaction_status_sva.sv
// Port assertions for the endpoint transaction status block.
// Assumes one clock domain; bound to the design at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep_status_regs.vh"
module usb_ep_status_sva #(
    parameter EP_COUNT = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic tok_setup,
    input wire logic tok_in,
    input wire logic tok_out,
    input wire logic tx_fifo_ready,
    input wire logic rx_fifo_ready,
    input wire logic rx_end,
    input wire logic rx_bad,
    input wire logic [1:0] handshake,
    input wire logic handshake_valid,
    input wire logic tx_data_toggle,
    input wire logic [EP_COUNT-1:0] rx_fifo_locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_tx_ovw_zero: assert property (reg_read && reg_addr == `ADDR_TX_STATUS |=>
        !reg_rdata[`TX_OVERWRITE_BIT]) else $error("tx overwrite bit read as one");
    chk_rx_ovw_zero: assert property (reg_read && reg_addr == `ADDR_RX_STATUS |=>
        !reg_rdata[`RX_OVERWRITE_BIT]) else $error("rx overwrite bit read as one");
    chk_in_unready_refused: assert property (tok_in && !tx_fifo_ready |=> handshake_valid &&
        (handshake == `HS_NAK || handshake == `HS_STALL)) else $error("unready IN not refused");
    chk_out_unready_noack: assert property (tok_out && !rx_fifo_ready |=>
        handshake_valid && handshake != `HS_ACK) else $error("unready OUT not refused");
    chk_bad_no_handshake: assert property (rx_end && rx_bad && !(tok_in || tok_out ||
        tok_setup) |=> !handshake_valid) else $error("handshake after bad packet");
    chk_ack_after_good: assert property (handshake_valid && handshake == `HS_ACK |->
        $past(rx_end && !rx_bad)) else $error("ACK without good reception");
    chk_toggle_held: assert property (!tok_in |=> $stable(tx_data_toggle))
        else $error("data toggle moved without IN token");
    chk_lock_after_setup: assert property ((rx_fifo_locked & ~$past(rx_fifo_locked)) != 0
        |-> $past(tok_setup)) else $error("receive lock without SETUP");
endmodule
bind usb_endpoint_transaction_status usb_ep_status_sva #(.EP_COUNT(EP_COUNT)) usb_ep_status_sva_i (.*);
`default_nettype wire

//--- usb_endpoint_transaction_status_bench.sv
// Bench for the endpoint status block: the bench plays firmware, the model plays the host.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep_status_regs.vh"
module usb_endpoint_transaction_status_bench;
    localparam logic [6:0] SU = 7'h01, IN = 7'h02, OUT = 7'h04, SOF = 7'h08;
    localparam logic [6:0] TXE = 7'h10, RXE = 7'h20, SHS = 7'h40;
    logic clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic tx_fifo_ready = 1'b1, rx_fifo_ready = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_fifo_set_flags = 8'h00;
    wire logic [7:0] reg_rdata;
    wire logic [1:0] tok_ep, handshake, last_hs;
    wire logic tok_setup, tok_in, tok_out, sof, tx_end, tx_ack_seen, rx_end, rx_bad;
    wire logic setup_handshake, handshake_valid, tx_data_toggle;
    wire logic [3:0] rx_fifo_locked, tx_flush_strobe, rx_fifo_reset;
    int mismatches = 0, n_tests = 0;
    usb_endpoint_transaction_status usb_endpoint_transaction_status_i (.*);
    usb_host_model usb_host_model_i (.*);
    // Free-running 50 MHz clock.
    initial begin
        forever #10 clk = ~clk;
    end
    task conclude;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobes drop one edge later and the next access waits an edge, so no double drive.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task rc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(nm, e, reg_rdata & m);
    endtask
    // The answer is registered one cycle after the strobe, then latched by the model.
    task hs(input string nm, input logic [1:0] e);
        repeat (2) @(posedge clk);
        #1 chk(nm, {6'h0, e}, {6'h0, last_hs});
    endtask
    task t_reset;
        rc("rx status", `ADDR_RX_STATUS, 8'hff, `STATUS_RESET);
        rc("tx status", `ADDR_TX_STATUS, 8'hff, `STATUS_RESET);
        rc("ep0 control", `ADDR_EP_CONTROL, 8'hff, `EP_CONTROL_EP0_RESET);
        rc("unmapped", 8'h10, 8'hff, 8'h00);
    endtask
    // Guarded toggle writes, then an acknowledged and a failed IN on endpoint 1.
    task t_tx;
        wr(`ADDR_EP_SELECT, 8'h01);
        wr(`ADDR_TX_STATUS, 8'h80);
        rc("tx plain write", `ADDR_TX_STATUS, 8'h88, 8'h00);
        wr(`ADDR_TX_STATUS, 8'h88);
        rc("tx overwrite", `ADDR_TX_STATUS, 8'h88, 8'h80);
        usb_host_model_i.send(IN, 2'd1, 1'b1);
        #1 chk("data toggle", 8'h01, {7'h0, tx_data_toggle});
        usb_host_model_i.send(TXE, 2'd1, 1'b1);
        rc("tx acked", `ADDR_TX_STATUS, 8'h87, 8'h01);
        rc("tx done", `ADDR_FIFO_FLAGS, 8'h0f, 8'h02);
        usb_host_model_i.send(IN, 2'd1, 1'b1);
        usb_host_model_i.send(TXE, 2'd1, 1'b0);
        rc("tx error", `ADDR_TX_STATUS, 8'h87, 8'h02);
    endtask
    // Refused IN: FIFO not ready, then a stalled endpoint.
    task t_void;
        @(posedge clk);
        tx_fifo_ready <= 1'b0;
        usb_host_model_i.send(IN, 2'd1, 1'b1);
        hs("in unready", `HS_NAK);
        usb_host_model_i.send(TXE, 2'd1, 1'b0);
        rc("tx void", `ADDR_TX_STATUS, 8'h04, 8'h04);
        @(posedge clk);
        tx_fifo_ready <= 1'b1;
        wr(`ADDR_EP_CONTROL, 8'h40);
        usb_host_model_i.send(IN, 2'd1, 1'b1);
        hs("in stalled", `HS_STALL);
        wr(`ADDR_EP_CONTROL, 8'h00);
    endtask
    // Good, corrupt and refused OUT transfers on endpoint 2.
    task t_rx;
        wr(`ADDR_EP_SELECT, 8'h02);
        usb_host_model_i.send(OUT, 2'd2, 1'b1);
        usb_host_model_i.send(RXE, 2'd2, 1'b1);
        hs("out ack", `HS_ACK);
        rc("rx acked", `ADDR_RX_STATUS, 8'h87, 8'h81);
        rc("rx done", `ADDR_FIFO_FLAGS, 8'hf0, 8'h40);
        usb_host_model_i.send(OUT, 2'd2, 1'b1);
        usb_host_model_i.send(RXE, 2'd2, 1'b0);
        hs("out bad", `HS_NONE);
        rc("rx error", `ADDR_RX_STATUS, 8'h87, 8'h82);
        @(posedge clk);
        rx_fifo_ready <= 1'b0;
        usb_host_model_i.send(OUT, 2'd2, 1'b1);
        hs("out unready", `HS_NAK);
        usb_host_model_i.send(RXE, 2'd2, 1'b1);
        rc("rx void", `ADDR_RX_STATUS, 8'h04, 8'h04);
        @(posedge clk);
        rx_fifo_ready <= 1'b1;
    endtask
    // SETUP on the control endpoint, its lock, the NAK over stall, and firmware release.
    task t_setup;
        wr(`ADDR_EP_SELECT, 8'h00);
        usb_host_model_i.send(SU, 2'd0, 1'b1);
        #1 chk("fifo reset", 8'h01, {4'h0, rx_fifo_reset});
        rc("setup start", `ADDR_RX_STATUS, 8'hf0, 8'he0);
        chk("fifo locked", 8'h01, {4'h0, rx_fifo_locked});
        rc("setup tx toggle", `ADDR_TX_STATUS, 8'h80, 8'h80);
        usb_host_model_i.send(RXE, 2'd0, 1'b1);
        usb_host_model_i.send(SHS, 2'd0, 1'b1);
        rc("setup end", `ADDR_RX_STATUS, 8'hf1, 8'hd1);
        wr(`ADDR_EP_CONTROL, 8'h60);
        usb_host_model_i.send(IN, 2'd0, 1'b1);
        hs("in during setup", `HS_NAK);
        wr(`ADDR_RX_STATUS, 8'h00);
        rc("setup cleared", `ADDR_RX_STATUS, 8'hf8, 8'h80);
        chk("fifo unlocked", 8'h00, {4'h0, rx_fifo_locked});
        wr(`ADDR_RX_STATUS, 8'h08);
        rc("rx overwrite", `ADDR_RX_STATUS, 8'h88, 8'h00);
        wr(`ADDR_EP_CONTROL, 8'h20);
    endtask
    // Isochronous outcome held until SOF, then stale flush by SOF and by a write.
    task t_iso;
        wr(`ADDR_EP_SELECT, 8'h03);
        wr(`ADDR_EP_CONTROL, 8'h10);
        usb_host_model_i.send(IN, 2'd3, 1'b1);
        usb_host_model_i.send(TXE, 2'd3, 1'b1);
        rc("iso held", `ADDR_TX_STATUS, 8'h07, 8'h00);
        usb_host_model_i.send(OUT, 2'd3, 1'b1);
        usb_host_model_i.send(RXE, 2'd3, 1'b1);
        rc("rx iso held", `ADDR_RX_STATUS, 8'h07, 8'h00);
        usb_host_model_i.send(SOF, 2'd0, 1'b1);
        rc("iso at sof", `ADDR_TX_STATUS, 8'h07, 8'h01);
        rc("rx iso at sof", `ADDR_RX_STATUS, 8'h07, 8'h01);
        @(posedge clk);
        tx_fifo_set_flags <= 8'hc0;
        usb_host_model_i.send(SOF, 2'd0, 1'b1);
        #1 chk("sof flush strobe", 8'h08, {4'h0, tx_flush_strobe});
        rc("flushed at sof", `ADDR_TX_STATUS, 8'h10, 8'h10);
        @(posedge clk);
        tx_fifo_set_flags <= 8'h00;
        wr(`ADDR_EP_SELECT, 8'h02);
        wr(`ADDR_TX_STATUS, 8'h10);
        #1 chk("write flush strobe", 8'h04, {4'h0, tx_flush_strobe});
        rc("flushed by write", `ADDR_TX_STATUS, 8'h10, 8'h10);
    endtask
    // A hang ends the run with a counted mismatch.
    initial begin
        for (int i = 0; i < 20000; i++) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_tx();
        t_void();
        t_rx();
        t_setup();
        t_iso();
        conclude();
    end
endmodule
`default_nettype wire
